// ===== rtl/mdc_pkg.sv
// mdc_pkg: register map, field layout, reset values and states of the mirror dimming control
package mdc_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // register byte offsets on the apb bus
  localparam logic [7:0] CTRL_OFS      = 8'h00;
  localparam logic [7:0] CFG_OFS       = 8'h04;
  localparam logic [7:0] DIAG_OFS      = 8'h08;
  localparam logic [7:0] VSTAT_OFS     = 8'h0C;
  localparam logic [7:0] IRQ_STAT_OFS  = 8'h10;
  localparam logic [7:0] IRQ_MASK_OFS  = 8'h14;

  ////////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int CTRL_CODE_LSB = 0;
  localparam int CTRL_EN_BIT   = 8;
  localparam int CTRL_HR_BIT   = 9;
  localparam int CTRL_FD_BIT   = 10;
  localparam int CTRL_OCR_BIT  = 11;
  localparam int CFG_MODE_LSB  = 0;
  localparam int CFG_UVSD_BIT  = 8;
  localparam int CFG_LOCK_BIT  = 9;
  localparam int CODE_W        = 6;
  localparam int MODE_W        = 4;

  // latched fault flags, same layout in diag, irq status and irq mask
  localparam int NUM_FLAGS = 8;
  localparam int F_SW_OC   = 0;
  localparam int F_SW_OL   = 1;
  localparam int F_SUP_OC  = 2;
  localparam int F_SUP_OL  = 3;
  localparam int F_OV      = 4;
  localparam int F_UV      = 5;
  localparam int F_TSD     = 6;
  localparam int F_CP      = 7;
  // live comparator inputs follow the flag inputs in the pin vector
  localparam int IN_VHI    = 8;
  localparam int IN_VNR    = 9;
  localparam int NUM_PINS  = 10;

  ////////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [CODE_W-1:0] CODE_RST  = 6'h00;
  localparam logic [MODE_W-1:0] MODE_RST  = 4'h0;
  localparam logic              UVSD_RST  = 1'b1;
  localparam logic              LOCK_RST  = 1'b1;
  localparam logic [7:0]        MASK_RST  = 8'h00;

  ////////////////////////////////////////////////////////////////////////////////
  // target scale: one step is full scale over 63, clamp limit derived from it
  localparam int EC_FULL_MV    = 1500;
  localparam int EC_LOW_MV     = 1200;
  localparam int EC_CODE_STEPS = 63;
  localparam logic [CODE_W-1:0] EC_LOW_MAX_CODE =
    CODE_W'(EC_LOW_MV * EC_CODE_STEPS / EC_FULL_MV);

  // supply output drive selections
  localparam logic [MODE_W-1:0] OUT_MODE_OFF = 4'h0;
  localparam logic [MODE_W-1:0] OUT_MODE_ON  = 4'h1;

  typedef enum logic [1:0] {
    ST_IDLE     = 2'b00,
    ST_REGULATE = 2'b01,
    ST_HALTED   = 2'b10
  } mdc_ec_state_type;

endpackage

// ===== rtl/mdc_top.sv
// mdc_top: electrochromic mirror voltage control with apb registers and fault handling
`timescale 1ns/1ps
`default_nettype none

module mdc_top (
  // apb slave
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [7:0]                 paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  // analog comparators and detectors, asynchronous
  input  wire logic                       ec_voltage_high_cmp,
  input  wire logic                       ec_voltage_low_cmp,
  input  wire logic                       ec_switch_oc_det,
  input  wire logic                       ec_switch_ol_det,
  input  wire logic                       mirror_supply_oc_det,
  input  wire logic                       mirror_supply_ol_det,
  input  wire logic                       supply_ov_det,
  input  wire logic                       supply_uv_det,
  input  wire logic                       thermal_shutdown_level_one,
  input  wire logic                       charge_pump_low_fault,
  // drive controls
  output logic [mdc_pkg::MODE_W-1:0]      mirror_supply_output,
  output logic                            ec_regulator_enable,
  output logic                            ec_gate_drive_pin_pulldown,
  output logic [mdc_pkg::CODE_W-1:0]      ec_target_level,
  output logic                            ec_discharge_switch_on,
  // interrupt
  output logic                            irq
);

  ////////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic [mdc_pkg::NUM_PINS-1:0]  s1;
    logic [mdc_pkg::NUM_PINS-1:0]  s2;
    logic [mdc_pkg::NUM_PINS-1:0]  s3;
    logic [mdc_pkg::NUM_PINS-1:0]  filt;
    logic [mdc_pkg::CODE_W-1:0]    code;
    logic                          ec_en;
    logic                          high_rng;
    logic                          fd_en;
    logic                          ocr_en;
    logic [mdc_pkg::MODE_W-1:0]    out_cfg;
    logic                          uvsd_en;
    logic                          lock_en;
    logic [mdc_pkg::NUM_FLAGS-1:0] flags;
    logic [mdc_pkg::NUM_FLAGS-1:0] istat;
    logic [mdc_pkg::NUM_FLAGS-1:0] imask;
    mdc_pkg::mdc_ec_state_type     st;
    logic [31:0]                   prdata;
    logic                          pready;
    logic                          pslverr;
    logic [mdc_pkg::MODE_W-1:0]    out_mode;
    logic                          reg_en;
    logic                          gate_pd;
    logic [mdc_pkg::CODE_W-1:0]    level;
    logic                          dis_on;
    logic                          irq;
  } mdc_state_type;

  localparam mdc_state_type STATE_RST = '{
    code:     mdc_pkg::CODE_RST,
    out_cfg:  mdc_pkg::MODE_RST,
    uvsd_en:  mdc_pkg::UVSD_RST,
    lock_en:  mdc_pkg::LOCK_RST,
    imask:    mdc_pkg::MASK_RST,
    st:       mdc_pkg::ST_IDLE,
    out_mode: mdc_pkg::OUT_MODE_OFF,
    gate_pd:  1'b1,
    default:  '0
  };

  mdc_state_type                 r;
  mdc_state_type                 n;
  logic [mdc_pkg::NUM_PINS-1:0]  pin_vec;
  logic                          acc_done;
  logic                          ctrl_wr;
  logic                          fault;
  logic [mdc_pkg::NUM_FLAGS-1:0] set_v;
  logic [mdc_pkg::NUM_FLAGS-1:0] clr_v;
  logic [mdc_pkg::NUM_FLAGS-1:0] rdclr_v;

  assign pin_vec = {ec_voltage_low_cmp, ec_voltage_high_cmp, charge_pump_low_fault,
                    thermal_shutdown_level_one, supply_uv_det, supply_ov_det,
                    mirror_supply_ol_det, mirror_supply_oc_det, ec_switch_ol_det,
                    ec_switch_oc_det};

  ////////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    n = r;
    // three-stage synchroniser; a change counts once stages two and three agree
    n.s1 = pin_vec;
    n.s2 = r.s1;
    n.s3 = r.s2;
    for (int i = 0; i < mdc_pkg::NUM_PINS; i++) begin
      if (r.s2[i] == r.s3[i]) begin
        n.filt[i] = r.s3[i];
      end
    end

    // apb access completes on the second access edge (one wait state)
    acc_done = psel & penable & r.pready;
    ctrl_wr  = acc_done & pwrite & (paddr == mdc_pkg::CTRL_OFS);
    clr_v    = '0;
    rdclr_v  = '0;
    if (acc_done && pwrite && paddr == mdc_pkg::DIAG_OFS) begin
      clr_v = pwdata[mdc_pkg::NUM_FLAGS-1:0];
    end
    // only bits actually returned to software are cleared, so late events survive
    if (acc_done && !pwrite && paddr == mdc_pkg::IRQ_STAT_OFS) begin
      rdclr_v = r.prdata[mdc_pkg::NUM_FLAGS-1:0];
    end

    // register writes
    if (acc_done && pwrite) begin
      unique case (paddr)
        mdc_pkg::CTRL_OFS: begin
          n.code     = pwdata[mdc_pkg::CTRL_CODE_LSB +: mdc_pkg::CODE_W];
          n.ec_en    = pwdata[mdc_pkg::CTRL_EN_BIT];
          n.high_rng = pwdata[mdc_pkg::CTRL_HR_BIT];
          n.fd_en    = pwdata[mdc_pkg::CTRL_FD_BIT];
          n.ocr_en   = pwdata[mdc_pkg::CTRL_OCR_BIT];
        end
        mdc_pkg::CFG_OFS: begin
          n.out_cfg = pwdata[mdc_pkg::CFG_MODE_LSB +: mdc_pkg::MODE_W];
          n.uvsd_en = pwdata[mdc_pkg::CFG_UVSD_BIT];
          n.lock_en = pwdata[mdc_pkg::CFG_LOCK_BIT];
        end
        mdc_pkg::IRQ_MASK_OFS: begin
          n.imask = pwdata[mdc_pkg::NUM_FLAGS-1:0];
        end
        default: begin
        end
      endcase
    end

    // fault flags latch; a set in the clearing cycle wins
    set_v = r.filt[mdc_pkg::NUM_FLAGS-1:0];
    if (r.ocr_en) begin
      set_v[mdc_pkg::F_SW_OC] = 1'b0;
    end
    n.flags = (r.flags & ~clr_v) | set_v;
    // without the lock, supply voltage flags track the detector and clear by themselves
    if (!r.lock_en) begin
      n.flags[mdc_pkg::F_OV] = r.filt[mdc_pkg::F_OV];
      n.flags[mdc_pkg::F_UV] = r.filt[mdc_pkg::F_UV];
    end
    n.istat = (r.istat & ~rdclr_v) | (n.flags & ~r.flags);

    // faults that shut the mirror block down; undervoltage may be exempt
    fault = r.flags[mdc_pkg::F_SUP_OC] | r.flags[mdc_pkg::F_OV]
          | (r.flags[mdc_pkg::F_UV] & r.uvsd_en) | r.flags[mdc_pkg::F_TSD]
          | r.flags[mdc_pkg::F_CP];

    // mirror control sequence
    unique case (r.st)
      mdc_pkg::ST_IDLE: begin
        if (n.ec_en) begin
          n.st = mdc_pkg::ST_REGULATE;
        end
      end
      mdc_pkg::ST_REGULATE: begin
        if (!n.ec_en) begin
          n.st = mdc_pkg::ST_IDLE;
        end else if (fault) begin
          n.st   = mdc_pkg::ST_HALTED;
          n.code = mdc_pkg::CODE_RST;
        end
      end
      mdc_pkg::ST_HALTED: begin
        // a target write after the flags are gone restarts regulation
        if (!n.ec_en) begin
          n.st = mdc_pkg::ST_IDLE;
        end else if (ctrl_wr && !fault) begin
          n.st = mdc_pkg::ST_REGULATE;
        end else begin
          n.code = mdc_pkg::CODE_RST;
        end
      end
      default: begin
        n.st = mdc_pkg::ST_IDLE;
      end
    endcase

    // supply output: forced on while regulating, off while halted, own selection else
    if (n.st == mdc_pkg::ST_REGULATE) begin
      n.out_mode = mdc_pkg::OUT_MODE_ON;
    end else if (n.st == mdc_pkg::ST_HALTED) begin
      n.out_mode = mdc_pkg::OUT_MODE_OFF;
    end else begin
      n.out_mode = n.out_cfg;
    end
    n.reg_en  = (n.st == mdc_pkg::ST_REGULATE);
    n.gate_pd = (n.st != mdc_pkg::ST_REGULATE);

    // applied target keeps the 1.5 V / 63 step; only the ceiling moves with range
    if (!n.high_rng && n.code > mdc_pkg::EC_LOW_MAX_CODE) begin
      n.level = mdc_pkg::EC_LOW_MAX_CODE;
    end else begin
      n.level = n.code;
    end

    // discharge switch needs enable, voltage above target and no switch overcurrent
    n.dis_on = n.ec_en & n.fd_en & n.filt[mdc_pkg::IN_VHI]
             & ~n.flags[mdc_pkg::F_SW_OC];

    n.irq = |(n.istat & n.imask);

    // first access edge: answer prepared, pready raised for the second access edge
    n.pready = psel & penable & ~r.pready;
    if (psel && penable && !r.pready) begin
      n.pslverr = 1'b0;
      unique case (paddr)
        mdc_pkg::CTRL_OFS: begin
          n.prdata = {20'h00000, r.ocr_en, r.fd_en, r.high_rng, r.ec_en, 2'h0, r.code};
        end
        mdc_pkg::CFG_OFS: begin
          n.prdata = {22'h000000, r.lock_en, r.uvsd_en, 4'h0, r.out_cfg};
        end
        mdc_pkg::DIAG_OFS: begin
          n.prdata = {24'h000000, n.flags};
        end
        mdc_pkg::VSTAT_OFS: begin
          n.prdata = {30'h00000000, r.filt[mdc_pkg::IN_VNR], r.filt[mdc_pkg::IN_VHI]};
        end
        mdc_pkg::IRQ_STAT_OFS: begin
          n.prdata = {24'h000000, n.istat};
        end
        mdc_pkg::IRQ_MASK_OFS: begin
          n.prdata = {24'h000000, r.imask};
        end
        default: begin
          n.prdata  = 32'h00000000;
          n.pslverr = 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= STATE_RST;
    end else begin
      r <= n;
    end
  end

  // all outputs straight from flip-flops
  assign prdata                     = r.prdata;
  assign pready                     = r.pready;
  assign pslverr                    = r.pslverr;
  assign mirror_supply_output       = r.out_mode;
  assign ec_regulator_enable        = r.reg_en;
  assign ec_gate_drive_pin_pulldown = r.gate_pd;
  assign ec_target_level            = r.level;
  assign ec_discharge_switch_on     = r.dis_on;
  assign irq                        = r.irq;

  ////////////////////////////////////////////////////////////////////////////////
  // assertions
  sequence s_fault_hit;
    r.st == mdc_pkg::ST_REGULATE && fault && !ctrl_wr;
  endsequence

  sequence s_halted_out;
    r.st == mdc_pkg::ST_HALTED && r.code == mdc_pkg::CODE_RST && r.ec_en
      && mirror_supply_output == mdc_pkg::OUT_MODE_OFF && ec_gate_drive_pin_pulldown;
  endsequence

  property p_force_on;
    @(posedge pclk) disable iff (!presetn)
      r.st == mdc_pkg::ST_REGULATE |-> mirror_supply_output == mdc_pkg::OUT_MODE_ON;
  endproperty
  a_force_on: assert property (p_force_on) else $error("supply not forced on");

  property p_restore;
    @(posedge pclk) disable iff (!presetn)
      $fell(r.ec_en) |-> mirror_supply_output == r.out_cfg;
  endproperty
  a_restore: assert property (p_restore) else $error("supply setting not restored");

  property p_zero_code;
    @(posedge pclk) disable iff (!presetn)
      r.code == mdc_pkg::CODE_RST |-> ec_target_level == mdc_pkg::CODE_RST;
  endproperty
  a_zero_code: assert property (p_zero_code) else $error("zero code not zero");

  property p_clamp;
    @(posedge pclk) disable iff (!presetn)
      !r.high_rng |-> ec_target_level <= mdc_pkg::EC_LOW_MAX_CODE;
  endproperty
  a_clamp: assert property (p_clamp) else $error("low range not clamped");

  property p_full_range;
    @(posedge pclk) disable iff (!presetn)
      r.high_rng |-> ec_target_level == r.code;
  endproperty
  a_full_range: assert property (p_full_range) else $error("high range altered code");

  property p_discharge_gate;
    @(posedge pclk) disable iff (!presetn)
      ec_discharge_switch_on |-> r.fd_en && r.filt[mdc_pkg::IN_VHI];
  endproperty
  a_discharge_gate: assert property (p_discharge_gate) else $error("switch on wrongly");

  property p_oc_off;
    @(posedge pclk) disable iff (!presetn)
      r.flags[mdc_pkg::F_SW_OC] |-> !ec_discharge_switch_on;
  endproperty
  a_oc_off: assert property (p_oc_off) else $error("switch on with overcurrent");

  property p_ocr_quiet;
    @(posedge pclk) disable iff (!presetn)
      $past(r.ocr_en) && !$past(r.flags[mdc_pkg::F_SW_OC]) |-> !r.flags[mdc_pkg::F_SW_OC];
  endproperty
  a_ocr_quiet: assert property (p_ocr_quiet) else $error("flag set under recovery");

  property p_fault_halt;
    @(posedge pclk) disable iff (!presetn)
      s_fault_hit |=> s_halted_out;
  endproperty
  a_fault_halt: assert property (p_fault_halt) else $error("fault shutdown wrong");

  property p_auto_clear;
    @(posedge pclk) disable iff (!presetn)
      !r.lock_en |=> r.flags[mdc_pkg::F_OV] == $past(r.filt[mdc_pkg::F_OV]);
  endproperty
  a_auto_clear: assert property (p_auto_clear) else $error("ov flag not tracking");

  property p_auto_clear_uv;
    @(posedge pclk) disable iff (!presetn)
      !r.lock_en |=> r.flags[mdc_pkg::F_UV] == $past(r.filt[mdc_pkg::F_UV]);
  endproperty
  a_auto_clear_uv: assert property (p_auto_clear_uv) else $error("uv flag not tracking");

  // a halted block must not keep the regulator running behind a switched-off supply
  property p_halt_quiet;
    @(posedge pclk) disable iff (!presetn)
      r.st == mdc_pkg::ST_HALTED |-> !ec_regulator_enable && ec_gate_drive_pin_pulldown;
  endproperty
  a_halt_quiet: assert property (p_halt_quiet) else $error("regulator on in halt");

  // one wait state: pready never stands two cycles, so a request held one cycle past completion is not taken twice
  property p_pready_pulse;
    @(posedge pclk) disable iff (!presetn)
      pready |=> !pready;
  endproperty
  a_pready_pulse: assert property (p_pready_pulse) else $error("pready held");

endmodule

`default_nettype wire

// ===== tb/mdc_glass_model.sv
// mdc_glass_model: mirror glass and outside transistor with its voltage comparators
`timescale 1ns/1ps
`default_nettype none
module mdc_glass_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // drive from the block
  input  wire logic       reg_en,
  input  wire logic       gate_pulldown,
  input  wire logic [5:0] target,
  input  wire logic       dis_on,
  // outside charge pushed in by the bench
  input  wire logic       boost,
  // comparator outputs
  output logic            vhi,
  output logic            vlo
);
  logic [6:0] v_r;
  logic [3:0] tick_r;

  ////////////////////////////////////////////////////////////////////////////////
  // charge creeps up slowly so a low reading can be seen over the bus
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      v_r    <= 7'h00;
      tick_r <= 4'h0;
    end else begin
      tick_r <= tick_r + 4'h1;
      if (boost) begin
        v_r <= (v_r < 7'h3F) ? v_r + 7'h01 : v_r;
      end else if (dis_on) begin
        v_r <= (v_r > 7'h02) ? v_r - 7'h02 : 7'h00;
      end else if (tick_r == 4'hF) begin
        if (reg_en && !gate_pulldown && v_r < {1'b0, target}) begin
          v_r <= v_r + 7'h01;
        end else if (v_r > {1'b0, target}) begin
          v_r <= v_r - 7'h01;
        end
      end
    end
  end

  // one code of margin each way, so a settled glass reads both low
  assign vhi = v_r > {1'b0, target} + 7'h01;
  assign vlo = reg_en && (v_r + 7'h01 < {1'b0, target});
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// tb_top: self-checking bench for the mirror dimming control
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int LIMIT = 60000;
  logic        pclk, presetn, psel, penable, pwrite, boost;
  logic        pready, pslverr, irq, vhi, vlo, err, reg_en, pulldn, dis_on;
  logic [7:0]  paddr, det;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  sup_out, mode;
  logic [5:0]  lvl, code;
  int          n_errors, compares, cyc;
  int          flt[5] = '{2, 4, 5, 6, 7};

  ////////////////////////////////////////////////////////////////////////////////
  // design and glass; det follows the diag flag layout
  mdc_top mdc_top_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ec_voltage_high_cmp(vhi), .ec_voltage_low_cmp(vlo),
    .ec_switch_oc_det(det[0]), .ec_switch_ol_det(det[1]),
    .mirror_supply_oc_det(det[2]), .mirror_supply_ol_det(det[3]),
    .supply_ov_det(det[4]), .supply_uv_det(det[5]),
    .thermal_shutdown_level_one(det[6]), .charge_pump_low_fault(det[7]),
    .mirror_supply_output(sup_out), .ec_regulator_enable(reg_en),
    .ec_gate_drive_pin_pulldown(pulldn), .ec_target_level(lvl),
    .ec_discharge_switch_on(dis_on), .irq(irq));
  mdc_glass_model mdc_glass_model_i (
    .clk(pclk), .rst_n(presetn), .reg_en(reg_en), .gate_pulldown(pulldn), .target(lvl),
    .dis_on(dis_on), .boost(boost), .vhi(vhi), .vlo(vlo));

  ////////////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  always #12.5 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_errors++;
      print_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // helpers
  task automatic print_verdict();
    if (n_errors == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // one apb transfer; an idle edge first keeps the release and next setup apart
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no local limit: a slave that never answers runs into the cycle guard
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [5:0] exp_lvl(input logic [5:0] c, input logic hr);
    return (hr || c <= mdc_pkg::EC_LOW_MAX_CODE) ? c : mdc_pkg::EC_LOW_MAX_CODE;
  endfunction
  function automatic logic [31:0] ctl(input logic [5:0] c, input logic en, hr, fd, ocr);
    return {20'h0, ocr, fd, hr, en, 2'b00, c};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, boost} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    det = 8'h00;
    n_errors = 0;
    compares = 0;
    cyc = 0;
    void'($urandom(32'h5048a194));
    wt(12);
    presetn <= 1'b1;
    wt(1);
    chk("rst_gate", pulldn, 1'b1);
    apb(mdc_pkg::CFG_OFS, 0, 0);
    chk("cfg_rst", rd, 32'h300);
    apb(mdc_pkg::CTRL_OFS, 0, 0);
    chk("ctrl_rst", rd, 32'h0);
    apb(8'h18, 1, 32'hFFFF);
    apb(8'h18, 0, 0);
    chk("unmap_err", err, 1'b1);
    chk("unmap_data", rd, 32'h0);
    apb(mdc_pkg::IRQ_MASK_OFS, 1, 32'h40);
    // own selection, forced on, clamp and scale
    mode = 4'(2 + $urandom % 10);
    // keep undervoltage shutdown and the fault lock on, as after reset
    apb(mdc_pkg::CFG_OFS, 1, {20'h00000, 4'h3, 4'h0, mode});
    wt(3);
    chk("own_sel", sup_out, mode);
    for (int i = 0; i < 12; i++) begin
      code = (i < 2) ? 6'(50 + i) : (i == 2) ? 6'h3F : 6'($urandom);
      apb(mdc_pkg::CTRL_OFS, 1, ctl(code, 1, i[0], 0, 0));
      wt(3);
      chk("level", lvl, exp_lvl(code, i[0]));
      chk("forced_on", sup_out, mdc_pkg::OUT_MODE_ON);
    end
    chk("gate_free", pulldn, 1'b0);
    chk("reg_on", reg_en, 1'b1);
    apb(mdc_pkg::CTRL_OFS, 1, ctl(6'h3F, 1, 1, 0, 0));
    wt(8);
    apb(mdc_pkg::VSTAT_OFS, 0, 0);
    chk("vstat_low", rd, 32'h2);
    apb(mdc_pkg::CTRL_OFS, 1, ctl(6'h14, 0, 0, 0, 0));
    wt(3);
    chk("restored", sup_out, mode);
    // discharge switch gating and its overcurrent
    apb(mdc_pkg::CTRL_OFS, 1, ctl(6'hA, 1, 0, 1, 0));
    boost <= 1'b1;
    wt(100);
    apb(mdc_pkg::VSTAT_OFS, 0, 0);
    chk("vstat_high", rd, 32'h1);
    chk("dis_on", dis_on, 1'b1);
    apb(mdc_pkg::CTRL_OFS, 1, ctl(6'hA, 1, 0, 0, 0));
    wt(3);
    chk("dis_off", dis_on, 1'b0);
    apb(mdc_pkg::CTRL_OFS, 1, ctl(6'hA, 1, 0, 1, 1));
    det <= 8'h01;
    wt(10);
    apb(mdc_pkg::DIAG_OFS, 0, 0);
    chk("ocr_quiet", rd, 32'h0);
    chk("ocr_on", dis_on, 1'b1);
    apb(mdc_pkg::CTRL_OFS, 1, ctl(6'hA, 1, 0, 1, 0));
    det <= 8'h03;
    wt(10);
    apb(mdc_pkg::DIAG_OFS, 0, 0);
    chk("sw_flags", rd, 32'h3);
    chk("oc_off", dis_on, 1'b0);
    det <= 8'h00;
    wt(10);
    chk("oc_held", dis_on, 1'b0);
    apb(mdc_pkg::DIAG_OFS, 1, 32'hFF);
    wt(3);
    chk("oc_clear", dis_on, 1'b1);
    boost <= 1'b0;
    wt(400);
    apb(mdc_pkg::VSTAT_OFS, 0, 0);
    chk("reached", rd, 32'h0);
    apb(mdc_pkg::IRQ_STAT_OFS, 0, 0);
    // every fault source halts, then restart after clearing
    foreach (flt[k]) begin
      apb(mdc_pkg::CTRL_OFS, 1, ctl(6'h28, 1, 0, 1, 0));
      det <= 8'(1 << flt[k]);
      wt(12);
      chk("sup_off", sup_out, mdc_pkg::OUT_MODE_OFF);
      chk("lvl_zero", lvl, 32'h0);
      chk("gate_low", pulldn, 1'b1);
      chk("reg_off", reg_en, 1'b0);
      chk("irq", irq, flt[k] == 6);
      apb(mdc_pkg::CTRL_OFS, 0, 0);
      chk("ctrl_kept", rd, ctl(6'h0, 1, 0, 1, 0));
      apb(mdc_pkg::IRQ_STAT_OFS, 0, 0);
      chk("irq_stat", rd, 32'(1 << flt[k]));
      det <= 8'h00;
      wt(10);
      chk("irq_clr", irq, 1'b0);
      apb(mdc_pkg::DIAG_OFS, 0, 0);
      chk("latched", rd, 32'(1 << flt[k]));
      apb(mdc_pkg::DIAG_OFS, 1, 32'hFF);
      apb(mdc_pkg::CTRL_OFS, 1, ctl(6'h28, 1, 0, 1, 0));
      wt(3);
      chk("restart", lvl, 32'h28);
    end
    // undervoltage exempt, then self-clearing supply flags without lock
    apb(mdc_pkg::CFG_OFS, 1, {28'h0, mode});
    det <= 8'h20;
    wt(12);
    chk("uv_ignored", lvl, 32'h28);
    det <= 8'h10;
    wt(12);
    chk("ov_halt", lvl, 32'h0);
    det <= 8'h00;
    wt(10);
    apb(mdc_pkg::DIAG_OFS, 0, 0);
    chk("auto_clr", rd & 32'h30, 32'h0);
    apb(mdc_pkg::CTRL_OFS, 1, ctl(6'h28, 1, 0, 0, 0));
    wt(3);
    chk("no_clr_restart", lvl, 32'h28);
    // supply open load stays latched and masked
    det <= 8'h08;
    wt(10);
    det <= 8'h00;
    wt(10);
    apb(mdc_pkg::DIAG_OFS, 0, 0);
    chk("sup_ol", rd, 32'h08);
    chk("masked", irq, 1'b0);
    print_verdict();
  end
endmodule
`default_nettype wire
